// >>> drf_assertions.sv
`timescale 1ns/1ps
module drf_assertions #(
   parameter int TREFI_CYC = 200,
   parameter int TXSRD_CYC = 200
)(
   // System
   input wire logic mclk,
   input wire logic rst_b,
   // Link
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_b,
   input wire logic ras_b,
   input wire logic cas_b,
   input wire logic we_b,
   input wire logic odt,
   input wire logic [1:0] ba,
   input wire logic a10
);
   logic ck_q, sr, pre_a10, ref_seen, rise, is_ref, is_sre, is_pre, is_nop;
   logic [15:0] since_pre, since_ref, sr_cnt, xs_cnt;
   assign rise = ck && !ck_q;
   assign is_ref = rise && !cs_b && !ras_b && !cas_b && we_b && cke;
   assign is_sre = rise && !cs_b && !ras_b && !cas_b && we_b && !cke;
   assign is_pre = rise && !cs_b && !ras_b && cas_b && !we_b;
   assign is_nop = rise && (cs_b || (ras_b && cas_b && we_b));
   // ----------------------------------------
   // Tracking
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ck_q <= 1'b0;
         sr <= 1'b0;
         pre_a10 <= 1'b0;
         ref_seen <= 1'b0;
         since_pre <= 16'h0;
         since_ref <= 16'h0;
         sr_cnt <= 16'h0;
         xs_cnt <= 16'hffff;
      end
      else
      begin
         ck_q <= ck;
         sr <= is_sre || (sr && !cke);
         pre_a10 <= is_pre ? a10 : pre_a10;
         ref_seen <= is_ref || (ref_seen && !(sr && cke));
         since_pre <= is_pre ? 16'h0 : since_pre + {15'h0, since_pre != 16'hffff};
         since_ref <= (is_ref || is_sre || sr) ? 16'h0 : since_ref + 16'h1;
         sr_cnt <= is_sre ? 16'h0 : sr_cnt + {15'h0, sr_cnt != 16'hffff};
         if (sr && cke)
            xs_cnt <= 16'h0;
         else if (rise && xs_cnt != 16'hffff)
            xs_cnt <= xs_cnt + 16'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_pre_before_ref: assert property (is_ref |-> since_pre >= 16'd4 && pre_a10)
      else $error("refresh without precharge all one link clock earlier");
   a_ref_spacing: assert property ((is_ref || is_sre) |-> since_ref >= 16'd4)
      else $error("refresh closer than refresh cycle time");
   a_ref_interval: assert property (!sr |-> since_ref <= 9 * TREFI_CYC)
      else $error("refresh gap above nine intervals");
   a_sr_min_stay: assert property (sr && cke |-> sr_cnt >= 16'd12)
      else $error("self refresh left before minimum period");
   a_exit_nop_only: assert property (rise && xs_cnt < TXSRD_CYC |-> is_nop)
      else $error("command issued during self refresh exit");
   a_exit_cke_high: assert property (!sr && xs_cnt < TXSRD_CYC |-> cke)
      else $error("clock enable dropped during exit period");
   a_odt_off: assert property ((is_sre || sr || xs_cnt < TXSRD_CYC) |-> !odt)
      else $error("termination on around self refresh");
   a_reentry_ref: assert property (is_sre |-> ref_seen)
      else $error("self refresh entered without extra refresh");
   a_ck_shape: assert property ($rose(ck) |=> ck ##1 !ck)
      else $error("link clock not two high cycles");
   c_ref: cover property (is_ref);
   c_sre: cover property (is_sre);
   c_exit: cover property (sr && cke);
endmodule : drf_assertions

// >>> drf_ctrl.sv
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_ctrl #(
   parameter int TREFI_CYC = `CYC_DN(`DRF_TREFI_NS, `DRF_MCLK_NS),
   parameter int TXSRD_CYC = `DRF_TXSRD_CK,
   parameter int POST_MAX = 8
)(
   // System
   input wire logic mclk,
   input wire logic rst_b,
   // Link
   drf_if.ctrl link,
   // User
   input wire logic sref_req,
   output logic in_sref,
   output logic busy
);
   localparam int CKD = `DRF_CKDIV;
   localparam int TRP = `CYC_UP(`DRF_TRP_NS, `DRF_MCLK_NS * CKD);
   localparam int RTP = `CYC_UP(`DRF_TRTP_NS, `DRF_MCLK_NS * CKD);
   localparam int TWR = `CYC_UP(`DRF_TWR_NS, `DRF_MCLK_NS * CKD);
   localparam int TRFC = `CYC_UP(`DRF_TRFC_NS, `DRF_MCLK_NS * CKD);
   localparam int TXSNR = `CYC_UP(`DRF_TXSNR_NS, `DRF_MCLK_NS * CKD);
   localparam int TREFI_CK = TREFI_CYC / CKD;
   typedef enum logic [2:0] {C_IDLE, C_PRE, C_REF, C_SENTER, C_SREF, C_XSNR, C_XSRD} drf_cst_t;
   // -------------------------
   // Precharge spacing
   // -------------------------
   // No reads or writes are issued here; the bounds still guard the first
   // precharge after reset, when a burst may have been cut short
   localparam int RTP_EFF = (RTP > 2) ? RTP : 2;
   localparam int RD_PRE = `DRF_AL + `DRF_BL / 2 + RTP_EFF - 2;
   localparam int WR_PRE = `DRF_WL + `DRF_BL / 2 + TWR;
   localparam int PRE_GUARD = (RD_PRE > WR_PRE) ? RD_PRE : WR_PRE;
   // -------------------------
   // Parameter checks
   // -------------------------
   if (POST_MAX < 1 || POST_MAX > 8)
   begin : g_bad_post
      $error("drf_ctrl: POST_MAX must lie in 1 to 8");
   end
   if (TREFI_CK < TRFC + 8 || TREFI_CK > 65534)
   begin : g_bad_trefi
      $error("drf_ctrl: TREFI_CYC out of range");
   end
   if (TXSRD_CYC < 1 || TXSRD_CYC > 65535)
   begin : g_bad_txsrd
      $error("drf_ctrl: TXSRD_CYC out of range");
   end
   if (CKD < 2 || CKD > 16 || CKD % 2 != 0)
   begin : g_bad_ckd
      $error("drf_ctrl: link clock divider must be even");
   end
   if (TRP > 65535 || TRFC > 65535 || TXSNR > 65535 || PRE_GUARD > 65535)
   begin : g_bad_wait
      $error("drf_ctrl: wait too long for the counter");
   end
   // -------------------------
   // Link clock divider
   // -------------------------
   logic [3:0] div, next_div;
   logic ck, next_ck;
   logic tick;
   always_comb
   begin
      next_div = (div == 4'(CKD / 2 - 1)) ? 4'h0 : div + 4'h1;
      next_ck = (div == 4'(CKD / 2 - 1)) ? ~ck : ck;
   end
   assign tick = (div == 4'(CKD / 2 - 1)) && ck; // ck falls, next rise issues
   always_ff @(posedge mclk)
   begin
      div <= rst_b ? next_div : 4'h0;
      ck <= rst_b ? next_ck : 1'b0;
   end
   // -------------------------
   // Command sequencer
   // -------------------------
   drf_cst_t st, next_st;
   logic [15:0] wait_c, next_wait_c;
   logic [15:0] ref_t, next_ref_t;
   logic cke, next_cke;
   drf_pkg::drf_cmd_t cmd, next_cmd;
   logic extra_ref, next_extra_ref;
   always_comb
   begin
      next_st = st;
      next_wait_c = wait_c;
      next_ref_t = ref_t;
      next_cke = cke;
      next_cmd = cmd;
      next_extra_ref = extra_ref;
      if (tick)
      begin
         next_cmd = drf_pkg::DRF_CMD_NOP;
         if (wait_c != 16'h0)
            next_wait_c = wait_c - 16'h1;
         if (st != C_SREF && ref_t != 16'hffff)
            next_ref_t = ref_t + 16'h1;
         unique case (st)
            C_IDLE:
               if (wait_c == 16'h0 && (ref_t >= 16'(TREFI_CK) || (sref_req && !extra_ref)))
               begin
                  next_cmd = drf_pkg::DRF_CMD_PRE; // Precharge all
                  next_wait_c = 16'(TRP);
                  next_st = C_PRE;
               end
               else if (wait_c == 16'h0 && sref_req && extra_ref)
               begin
                  next_cmd = drf_pkg::DRF_CMD_SREF;
                  next_cke = 1'b0;
                  next_wait_c = 16'(`DRF_TCKE_CK);
                  next_st = C_SENTER;
               end
            C_PRE:
               if (wait_c == 16'h0)
               begin
                  next_cmd = drf_pkg::DRF_CMD_REF;
                  next_wait_c = 16'(TRFC);
                  next_ref_t = 16'h0;
                  next_extra_ref = 1'b1;
                  next_st = C_REF;
               end
            C_REF:
               if (wait_c == 16'h0)
                  next_st = C_IDLE;
            C_SENTER:
               if (wait_c == 16'h0)
                  next_st = C_SREF;
            C_SREF:
               if (!sref_req)
               begin
                  next_cke = 1'b1;
                  next_wait_c = 16'(TXSNR);
                  next_extra_ref = 1'b0;
                  next_st = C_XSNR;
               end
            C_XSNR:
               if (wait_c == 16'h0)
               begin
                  next_wait_c = 16'(TXSRD_CYC);
                  next_ref_t = 16'(TREFI_CK);
                  next_st = C_XSRD;
               end
            C_XSRD:
               if (wait_c == 16'h0)
               begin
                  next_wait_c = 16'h0;
                  next_st = C_IDLE;
               end
         endcase
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st <= C_IDLE;
         wait_c <= 16'(PRE_GUARD);
         ref_t <= 16'h0;
         cke <= 1'b1;
         cmd <= drf_pkg::DRF_CMD_NOP;
         extra_ref <= 1'b0;
      end
      else
      begin
         st <= next_st;
         wait_c <= next_wait_c;
         ref_t <= next_ref_t;
         cke <= next_cke;
         cmd <= next_cmd;
         extra_ref <= next_extra_ref;
      end
   end
   // -------------------------
   // Command pins
   // -------------------------
   // Pin order: cs_b, ras_b, cas_b, we_b
   function automatic logic [3:0] drf_pins(input drf_pkg::drf_cmd_t c);
      logic [3:0] p;
      case (c)
         drf_pkg::DRF_CMD_REF, drf_pkg::DRF_CMD_SREF: p = 4'h1;
         drf_pkg::DRF_CMD_PRE: p = 4'h2;
         drf_pkg::DRF_CMD_ACT: p = 4'h3;
         drf_pkg::DRF_CMD_RD: p = 4'h5;
         drf_pkg::DRF_CMD_WR: p = 4'h4;
         default: p = 4'hf;
      endcase
      return p;
   endfunction : drf_pins
   logic [3:0] pins;
   assign pins = drf_pins(cmd);
   always_comb
   begin
      link.ck = ck;
      link.cke = cke;
      link.cs_b = pins[3];
      link.ras_b = pins[2];
      link.cas_b = pins[1];
      link.we_b = pins[0];
      link.odt = 1'b0;
      link.ba = 2'h0;
      link.a10 = (cmd == drf_pkg::DRF_CMD_PRE);
   end
   // -------------------------
   // Status
   // -------------------------
   assign in_sref = (st == C_SENTER) || (st == C_SREF);
   assign busy = (st != C_IDLE);
endmodule : drf_ctrl

// >>> drf_defs.svh
`ifndef DRF_DEFS_SVH
`define DRF_DEFS_SVH
`define DRF_MCLK_NS 40
`define DRF_TRP_NS 15
`define DRF_TRTP_NS 8
`define DRF_TWR_NS 15
`define DRF_TRFC_NS 105
`define DRF_TREFI_NS 7800
`define DRF_TXSNR_NS 115
`define DRF_TXSRD_CK 200
`define DRF_TCKE_CK 3
`define DRF_AL 0
`define DRF_BL 4
`define DRF_WL 2
`define DRF_REF_POST 9
`define DRF_CKDIV 4
`define DRF_ROW_W 13
`define DRF_BANK_W 2
`define DRF_CNT_W 16
`define CYC_UP(ns, ckns) (((ns) + (ckns) - 1) / (ckns))
`define CYC_DN(ns, ckns) ((ns) / (ckns))
`endif

// >>> drf_if.sv
`timescale 1ns/1ps
interface drf_if;
   logic ck;
   logic cke;
   logic cs_b;
   logic ras_b;
   logic cas_b;
   logic we_b;
   logic odt;
   logic [1:0] ba;
   logic a10;
   modport ctrl (output ck, cke, cs_b, ras_b, cas_b, we_b, odt, ba, a10);
   modport mem (input ck, cke, cs_b, ras_b, cas_b, we_b, odt, ba, a10);
endinterface : drf_if

// >>> drf_mem.sv
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_mem #(
   parameter int TREFI_CYC = `CYC_DN(`DRF_TREFI_NS, `DRF_MCLK_NS),
   parameter int ROW_W = `DRF_ROW_W
)(
   // System
   input wire logic mclk,
   input wire logic rst_b,
   // Link
   drf_if.mem link,
   // Status
   output logic [3:0] bank_open,
   output logic [ROW_W-1:0] ref_row,
   output logic [1:0] ref_bank,
   output logic in_sref,
   output logic dll_on,
   output logic clk_gated,
   output logic ref_pulse
);
   if (ROW_W < 1 || ROW_W > 16 || TREFI_CYC < 2 || TREFI_CYC > 65535)
   begin : g_bad_par
      $error("drf_mem: parameters out of range");
   end
   typedef enum logic [1:0] {M_NORM, M_SREF} drf_mst_t;
   // -------------------------
   // Input synchronisers
   // -------------------------
   logic [6:0] s1, s2;
   logic ck_d;
   always_ff @(posedge mclk)
   begin
      s1 <= {link.ck, link.cke, link.cs_b, link.ras_b, link.cas_b, link.we_b, link.a10};
      s2 <= s1;
      ck_d <= s2[6];
   end
   logic rise;
   drf_pkg::drf_cmd_t cmd;
   assign rise = s2[6] && !ck_d;
   assign cmd = drf_pkg::drf_decode(s2[4], s2[3], s2[2], s2[1], s2[5]);
   // -------------------------
   // Refresh and self refresh
   // -------------------------
   drf_mst_t st, next_st;
   logic [3:0] next_bank_open;
   logic [ROW_W-1:0] next_ref_row;
   logic [1:0] next_ref_bank;
   logic [15:0] tmr, next_tmr;
   logic next_ref_pulse;
   always_comb
   begin
      next_st = st;
      next_bank_open = bank_open;
      next_ref_row = ref_row;
      next_ref_bank = ref_bank;
      next_tmr = tmr;
      next_ref_pulse = 1'b0;
      unique case (st)
         M_NORM:
            if (rise)
               unique case (cmd)
                  drf_pkg::DRF_CMD_REF, drf_pkg::DRF_CMD_SREF:
                  begin
                     next_ref_pulse = 1'b1;
                     next_ref_bank = ref_bank + 2'h1;
                     if (ref_bank == 2'h3)
                        next_ref_row = ref_row + 1'b1;
                     next_bank_open = 4'h0;
                     next_tmr = 16'h0;
                     if (cmd == drf_pkg::DRF_CMD_SREF)
                        next_st = M_SREF;
                  end
                  drf_pkg::DRF_CMD_ACT: next_bank_open = 4'hf;
                  drf_pkg::DRF_CMD_PRE: next_bank_open = 4'h0;
                  default: next_bank_open = bank_open;
               endcase
         M_SREF:
         begin
            // Only cke observed; link clock not needed
            if (tmr >= 16'(TREFI_CYC - 1))
            begin
               next_tmr = 16'h0;
               next_ref_pulse = 1'b1;
               next_ref_bank = ref_bank + 2'h1;
               if (ref_bank == 2'h3)
                  next_ref_row = ref_row + 1'b1;
            end
            else
               next_tmr = tmr + 16'h1;
            if (s2[5])
               next_st = M_NORM;
         end
         default: next_st = M_NORM;
      endcase
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st <= M_NORM;
         bank_open <= 4'h0;
         ref_row <= '0;
         ref_bank <= 2'h0;
         tmr <= 16'h0;
         ref_pulse <= 1'b0;
      end
      else
      begin
         st <= next_st;
         bank_open <= next_bank_open;
         ref_row <= next_ref_row;
         ref_bank <= next_ref_bank;
         tmr <= next_tmr;
         ref_pulse <= next_ref_pulse;
      end
   end
   assign in_sref = (st == M_SREF);
   assign dll_on = (st != M_SREF);
   assign clk_gated = (st == M_SREF);
endmodule : drf_mem

// >>> drf_pkg.sv
package drf_pkg;
   typedef enum logic [2:0]
   {
      DRF_CMD_NOP,
      DRF_CMD_REF,
      DRF_CMD_SREF,
      DRF_CMD_PRE,
      DRF_CMD_ACT,
      DRF_CMD_RD,
      DRF_CMD_WR,
      DRF_CMD_OTHER
   } drf_cmd_t;
   function automatic drf_cmd_t drf_decode(input logic cs_b, input logic ras_b,
                                           input logic cas_b, input logic we_b,
                                           input logic cke);
      drf_cmd_t c;
      c = DRF_CMD_OTHER;
      if (cs_b || (ras_b && cas_b && we_b))
         c = DRF_CMD_NOP;
      else if (!ras_b && !cas_b && we_b)
         c = cke ? DRF_CMD_REF : DRF_CMD_SREF;
      else if (!ras_b && cas_b && !we_b)
         c = DRF_CMD_PRE;
      else if (!ras_b && cas_b && we_b)
         c = DRF_CMD_ACT;
      else if (ras_b && !cas_b && we_b)
         c = DRF_CMD_RD;
      else if (ras_b && !cas_b && !we_b)
         c = DRF_CMD_WR;
      return c;
   endfunction : drf_decode
endpackage : drf_pkg

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic sref_req = 1'b0;
   logic c_in_sref, c_busy, in_sref, dll_on, clk_gated, ref_pulse;
   logic [3:0] bank_open;
   logic [12:0] ref_row;
   logic [1:0] ref_bank;
   logic [2:0] note_q [$];
   logic [2:0] note;
   logic was_sr = 1'b0;
   logic row_pend = 1'b0;
   logic [15:0] pulses = 16'h0;
   int miscompares = 0;
   int samples_checked = 0;
   int seed = 32'hb0e13984;
   int hold, n, p0;
   localparam int TB_CTRL_TREFI = 200;
   localparam int TB_MEM_TREFI = 20;
   localparam int TB_TXSRD = 200;
   drf_if link ();
   always #20 mclk = ~mclk;
   drf_ctrl #(.TREFI_CYC(TB_CTRL_TREFI), .TXSRD_CYC(TB_TXSRD)) drf_ctrl_i (.mclk(mclk),
      .rst_b(rst_b), .link(link),
      .sref_req(sref_req), .in_sref(c_in_sref), .busy(c_busy));
   drf_mem #(.TREFI_CYC(TB_MEM_TREFI)) drf_mem_i (.mclk(mclk), .rst_b(rst_b), .link(link),
      .bank_open(bank_open), .ref_row(ref_row), .ref_bank(ref_bank), .in_sref(in_sref),
      .dll_on(dll_on), .clk_gated(clk_gated), .ref_pulse(ref_pulse));
   drf_assertions #(.TREFI_CYC(TB_CTRL_TREFI), .TXSRD_CYC(TB_TXSRD)) drf_assertions_i (.mclk(mclk),
      .rst_b(rst_b), .ck(link.ck), .cke(link.cke), .cs_b(link.cs_b), .ras_b(link.ras_b),
      .cas_b(link.cas_b), .we_b(link.we_b), .odt(link.odt), .ba(link.ba), .a10(link.a10));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic wait_sr(input logic mem_side, input logic want);
      n = 0;
      while ((mem_side ? in_sref : c_in_sref) !== want && n < 3000)
      begin
         @(posedge mclk);
         n++;
      end
      if (n == 3000)
      begin
         miscompares++;
         wrap_up();
      end
   endtask : wait_sr
   always @(posedge mclk)
   begin
      if (rst_b)
      begin
         if (in_sref !== was_sr)
         begin
            note = (note_q.size() > 0) ? note_q.pop_front() : 3'bxxx;
            chk("sref state", {13'h0, in_sref, dll_on, clk_gated}, {13'h0, note});
         end
         was_sr = in_sref;
         if (row_pend)
         begin
            chk("refresh row", {3'h0, ref_row}, {3'h0, pulses[14:2]});
            chk("refresh bank", {14'h0, ref_bank}, {14'h0, pulses[1:0]});
            chk("banks idle", {12'h0, bank_open}, 16'h0);
         end
         row_pend = (ref_pulse === 1'b1);
         if (row_pend)
            pulses = pulses + 16'h1;
      end
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         repeat (($random(seed) & 32'h1ff) + 1) @(posedge mclk);
         hold = (i == 0) ? 1 : ($random(seed) & 32'h1ff) + 1;
         note_q.push_back(3'b101);
         sref_req <= 1'b1;
         wait_sr(1'b0, 1'b1);
         p0 = pulses;
         chk("ctrl busy", {15'h0, c_busy}, 16'h1);
         wait_sr(1'b1, 1'b1);
         repeat (12) @(posedge mclk);
         chk("refresh in tcke", {15'h0, pulses != p0[15:0]}, 16'h1);
         repeat (hold) @(posedge mclk);
         chk("sr refreshes", {15'h0, (int'(pulses) - p0) >= hold / TB_MEM_TREFI}, 16'h1);
         note_q.push_back(3'b010);
         sref_req <= 1'b0;
         wait_sr(1'b1, 1'b0);
         wait_sr(1'b0, 1'b0);
      end
      repeat (1000) @(posedge mclk);
      chk("queue empty", {15'h0, note_q.size() == 0}, 16'h1);
      wrap_up();
   end
endmodule : testbench
